/* File: gpmx_pkg.sv */
// Package with register map, reset values and field positions.
package gpmx_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_PORT_E_PIN_LEVELS_PINS = 12'h000;
  localparam logic [11:0] ADDR_PORT_E_PIN_LEVELS_LAT = 12'h004;
  localparam logic [11:0] ADDR_PORT_E_PIN_LEVELS_DIR = 12'h008;
  localparam logic [11:0] ADDR_PORT_G_PINS_AND_PULLUPS = 12'h00c;
  localparam logic [11:0] ADDR_SECOND_PORT_PINS_PINS = 12'h010;
  localparam logic [11:0] ADDR_SECOND_PORT_PINS_LAT = 12'h014;
  localparam logic [11:0] ADDR_SECOND_PORT_PINS_DIR = 12'h018;
  localparam logic [11:0] ADDR_ANA_LOW = 12'h01c;
  localparam logic [11:0] ADDR_ANA_HIGH = 12'h020;
  localparam logic [11:0] ADDR_CMP_CTRL = 12'h024;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_LAT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PORT_G_PINS_AND_PULLUPS = 8'h00;
  localparam logic [7:0] RST_ANA = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PORT_G_PINS_AND_PULLUPS_PU_J_BIT = 5;
  localparam int ANA_LOW_F1_BIT = 6;
  localparam int ANA_LOW_F2_BIT = 7;
  localparam int ANA_HIGH_F3_BIT = 0;
  localparam int CMP_ENABLE_BIT = 0;
  localparam logic [7:0] PORT_G_PINS_AND_PULLUPS_WR_MASK = 8'hff;
endpackage

/* File: gpmx_port.sv */
// Pin multiplexer and GPIO for port E (pins 5..7) and the second port.
module gpmx_port #(
  parameter bit LARGE_PKG = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration fuses
  input wire logic pwm1_pin_select_fuse_i,
  input wire logic pwm2_pin_select_fuse_i,
  input wire logic parallel_master_pin_select_fuse_i,
  input wire logic micro_mode_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // External memory interface, bits 13..15
  input wire logic ext_bus_en_i,
  input wire logic ext_bus_drive_i,
  input wire logic [2:0] ext_bus_out_i,
  output logic [2:0] ext_bus_in_o,
  // Parallel master port
  input wire logic pm_en_i,
  input wire logic [2:0] parallel_master_addr_i,
  input wire logic pm_data_drive_i,
  input wire logic [1:0] pm_data_out_i,
  output logic [1:0] pm_data_in_o,
  // Enhanced PWM
  input wire logic pwm1_b_en_i,
  input wire logic pwm1_b_i,
  input wire logic pwm1_c_en_i,
  input wire logic pwm1_c_i,
  input wire logic pwm2_a_en_i,
  input wire logic pwm2_a_i,
  input wire logic pwm2_cmp_en_i,
  input wire logic pwm2_cmp_i,
  input wire logic pwm_shutdown_i,
  input wire logic [2:0] pwm_tristate_cfg_i,
  output logic pwm2_capture_o,
  // Comparators
  input wire logic [1:0] cmp_out_i,
  output logic [6:0] cmp_in_sel_o,
  // Analog converter channel enables (pins 1..6)
  output logic [5:0] analog_en_o,
  // Port E pins 5..7
  input wire logic [2:0] pe_pad_i,
  output logic [2:0] pe_pad_o,
  output logic [2:0] pe_pad_oe_o,
  // Second port pins 1..7
  input wire logic [6:0] pf_pad_i,
  output logic [6:0] pf_pad_o,
  output logic [6:0] pf_pad_oe_o,
  // Pull-up enables from port G
  output logic [2:0] pullup_o
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] pe_s1_q, pe_s2_q;
  logic [6:0] pf_s1_q, pf_s2_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_s1_q <= 3'h0;
      pe_s2_q <= 3'h0;
      pf_s1_q <= 7'h00;
      pf_s2_q <= 7'h00;
    end else begin
      pe_s1_q <= pe_pad_i;
      pe_s2_q <= pe_s1_q;
      pf_s1_q <= pf_pad_i;
      pf_s2_q <= pf_s1_q;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0] pe_lat_q, pe_dir_q, port_g_pins_and_pullups_q;
  logic [6:0] pf_lat_q, pf_dir_q;
  logic [7:0] ana_low_q, ana_high_q, cmp_q;
  logic wr_en;
  assign wr_en = psel_i && penable_i && pwrite_i;

  // Software writes to the port land in the latch.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_lat_q <= gpmx_pkg::RST_LAT;
      pf_lat_q <= gpmx_pkg::RST_LAT[6:0];
    end else if (wr_en) begin
      if (paddr_i == gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_PINS ||
          paddr_i == gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_LAT) begin
        pe_lat_q <= pwdata_i[7:0];
      end
      if (paddr_i == gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS ||
          paddr_i == gpmx_pkg::ADDR_SECOND_PORT_PINS_LAT) begin
        pf_lat_q <= pwdata_i[7:1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_dir_q <= gpmx_pkg::RST_DIR;
      pf_dir_q <= gpmx_pkg::RST_DIR[6:0];
      port_g_pins_and_pullups_q <= gpmx_pkg::RST_PORT_G_PINS_AND_PULLUPS;
    end else if (wr_en) begin
      if (paddr_i == gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_DIR) begin
        pe_dir_q <= pwdata_i[7:0];
      end
      if (paddr_i == gpmx_pkg::ADDR_SECOND_PORT_PINS_DIR) begin
        pf_dir_q <= pwdata_i[7:1];
      end
      if (paddr_i == gpmx_pkg::ADDR_PORT_G_PINS_AND_PULLUPS) begin
        port_g_pins_and_pullups_q <= pwdata_i[7:0] & gpmx_pkg::PORT_G_PINS_AND_PULLUPS_WR_MASK;
      end
    end
  end

  // Analog configuration resets to all-analog.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ana_low_q <= gpmx_pkg::RST_ANA;
      ana_high_q <= gpmx_pkg::RST_ANA;
      cmp_q <= gpmx_pkg::RST_CMP;
    end else if (wr_en) begin
      if (paddr_i == gpmx_pkg::ADDR_ANA_LOW) begin
        ana_low_q <= pwdata_i[7:0];
      end
      if (paddr_i == gpmx_pkg::ADDR_ANA_HIGH) begin
        ana_high_q <= pwdata_i[7:0];
      end
      if (paddr_i == gpmx_pkg::ADDR_CMP_CTRL) begin
        cmp_q <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Second port analog and digital selection
  // ----------------------------------------------------------------------
  // Digital enable per pin 1..6; pin 7 has no analog function.
  logic [6:0] pf_digital;
  assign pf_digital = {1'b1,
    ana_high_q[gpmx_pkg::ANA_HIGH_F3_BIT +: 4],
    ana_low_q[gpmx_pkg::ANA_LOW_F2_BIT],
    ana_low_q[gpmx_pkg::ANA_LOW_F1_BIT]};
  logic [6:0] pf_read;
  assign pf_read = pf_s2_q & pf_digital;

  // ----------------------------------------------------------------------
  // Port E pin 5..7 multiplexing
  // ----------------------------------------------------------------------
  logic pwm1_here, pwm2_here, pm_addr_here, ext_here, pm_data_here;
  assign pwm1_here = LARGE_PKG && pwm1_pin_select_fuse_i;
  assign pwm2_here = !pwm2_pin_select_fuse_i && micro_mode_i;
  assign pm_addr_here = parallel_master_pin_select_fuse_i && pm_en_i;
  assign ext_here = LARGE_PKG && ext_bus_en_i;
  assign pm_data_here = LARGE_PKG && !parallel_master_pin_select_fuse_i &&
                        pm_en_i;

  logic [2:0] pe_o_d, pe_oe_d;
  logic [2:0] pwm_en, pwm_val;
  always_comb begin
    pwm_en = {pwm2_here && (pwm2_a_en_i || pwm2_cmp_en_i),
              pwm1_here && pwm1_b_en_i,
              pwm1_here && pwm1_c_en_i};
    pwm_val = {pwm2_a_en_i ? pwm2_a_i : pwm2_cmp_i, pwm1_b_i, pwm1_c_i};
    for (int i = 0; i < 3; i++) begin
      pe_o_d[i] = pe_lat_q[5 + i];
      pe_oe_d[i] = !pe_dir_q[5 + i];
      if (ext_here) begin
        pe_o_d[i] = ext_bus_out_i[i];
        pe_oe_d[i] = ext_bus_drive_i;
      end else if (pwm_en[i] && !pe_dir_q[5 + i]) begin
        pe_o_d[i] = pwm_val[i];
        // Only PWM channels may float in shutdown; compare output stays.
        pe_oe_d[i] = !(pwm_shutdown_i && pwm_tristate_cfg_i[i] &&
                       (i != 2 || pwm2_a_en_i));
      end else if (pm_addr_here) begin
        pe_o_d[i] = parallel_master_addr_i[2 - i];
        pe_oe_d[i] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Second port pin multiplexing
  // ----------------------------------------------------------------------
  // Comparator outputs sit on pins 1 and 2 when enabled.
  logic [6:0] pf_o_d, pf_oe_d;
  logic cmp_on;
  assign cmp_on = cmp_q[gpmx_pkg::CMP_ENABLE_BIT];
  always_comb begin
    pf_o_d = pf_lat_q;
    pf_oe_d = ~pf_dir_q;
    if (cmp_on) begin
      pf_o_d[0] = cmp_out_i[1];
      pf_oe_d[0] = 1'b1;
      pf_o_d[1] = cmp_out_i[0];
      pf_oe_d[1] = 1'b1;
    end
    // The external bus never uses this port, so it cannot block the data.
    if (pm_data_here) begin
      pf_o_d[5:4] = {pm_data_out_i[0], pm_data_out_i[1]};
      pf_oe_d[5:4] = {2{pm_data_drive_i}};
    end
  end

  // ----------------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_pad_o <= 3'h0;
      pe_pad_oe_o <= 3'h0;
      pf_pad_o <= 7'h00;
      pf_pad_oe_o <= 7'h00;
    end else begin
      pe_pad_o <= pe_o_d;
      pe_pad_oe_o <= pe_oe_d;
      pf_pad_o <= pf_o_d;
      pf_pad_oe_o <= pf_oe_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_bus_in_o <= 3'h0;
      pm_data_in_o <= 2'h0;
      pwm2_capture_o <= 1'b0;
      cmp_in_sel_o <= 7'h00;
      analog_en_o <= 6'h3f;
      pullup_o <= 3'h0;
    end else begin
      ext_bus_in_o <= ext_here ? pe_s2_q : 3'h0;
      pm_data_in_o <= pm_data_here ? {pf_s2_q[4], pf_s2_q[5]} : 2'h0;
      pwm2_capture_o <= pwm2_here && pe_dir_q[7] && pe_s2_q[2];
      cmp_in_sel_o <= cmp_on ? 7'h7c : 7'h00;
      analog_en_o <= ~pf_digital[5:0];
      pullup_o <= {port_g_pins_and_pullups_q[7:6], LARGE_PKG &
                   port_g_pins_and_pullups_q[gpmx_pkg::PORT_G_PINS_AND_PULLUPS_PU_J_BIT]};
    end
  end

  // ----------------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------------
  logic [7:0] rd_d;
  logic hit;
  always_comb begin
    hit = 1'b1;
    rd_d = 8'h00;
    case (paddr_i)
      gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_PINS: rd_d = {pe_s2_q, 5'h00};
      gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_LAT: rd_d = pe_lat_q;
      gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_DIR: rd_d = pe_dir_q;
      gpmx_pkg::ADDR_PORT_G_PINS_AND_PULLUPS: begin
        rd_d = port_g_pins_and_pullups_q;
        rd_d[gpmx_pkg::PORT_G_PINS_AND_PULLUPS_PU_J_BIT] = LARGE_PKG &
          port_g_pins_and_pullups_q[gpmx_pkg::PORT_G_PINS_AND_PULLUPS_PU_J_BIT];
      end
      gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS: rd_d = {pf_read, 1'b0};
      gpmx_pkg::ADDR_SECOND_PORT_PINS_LAT: rd_d = {pf_lat_q, 1'b0};
      gpmx_pkg::ADDR_SECOND_PORT_PINS_DIR: rd_d = {pf_dir_q, 1'b0};
      gpmx_pkg::ADDR_ANA_LOW: rd_d = ana_low_q;
      gpmx_pkg::ADDR_ANA_HIGH: rd_d = ana_high_q;
      gpmx_pkg::ADDR_CMP_CTRL: rd_d = cmp_q;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait state: ready is raised in every access phase.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !hit;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ?
                  {24'h000000, rd_d} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Pin outputs are registered, so every check looks one edge later.
  a_ext_priority: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ext_here && ext_bus_drive_i |=> pe_pad_oe_o == 3'h7
      && pe_pad_o == $past(ext_bus_out_i))
    else $error("external bus lost pin priority");
  a_pwm_override: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ext_here && pwm1_here && pwm1_c_en_i && !pe_dir_q[5] && !pwm_shutdown_i
    |=> pe_pad_oe_o[0] && pe_pad_o[0] == $past(pwm1_c_i))
    else $error("pwm did not override pin 5");
  a_shutdown_tri: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ext_here && pwm1_here && pwm1_b_en_i && !pe_dir_q[6] &&
    pwm_shutdown_i && pwm_tristate_cfg_i[1] |=> !pe_pad_oe_o[1])
    else $error("pwm pin not tri-stated in shutdown");
  a_pm_addr: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ext_here && !(|pwm_en) && pm_addr_here |=> pe_pad_oe_o == 3'h7
      && pe_pad_o[2] == $past(parallel_master_addr_i[0]))
    else $error("pin 7 lacks address bit 9");
  a_capture_in: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pwm2_here && pe_dir_q[7] ##1 $stable(pe_dir_q) && pwm2_here
    |=> pwm2_capture_o == $past(pe_s2_q[2]))
    else $error("capture input not fed");
  a_analog_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !psel_i ##1 psel_i && !penable_i && !pwrite_i &&
    paddr_i == gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS && ana_low_q == 8'h00 &&
    ana_high_q == 8'h00 |=> prdata_o[6:1] == 6'h00)
    else $error("analog pins read nonzero");
  a_pullup_j: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !LARGE_PKG |=> !pullup_o[0])
    else $error("port J pull-up set on small package");
  a_latch_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !cmp_on && !pm_data_here && !pf_dir_q[6] |=>
      pf_pad_oe_o[6] && pf_pad_o[6] == $past(pf_lat_q[6]))
    else $error("latch drive lost on pin 7");
  a_pm_data: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pm_data_here && pm_data_drive_i |=> pf_pad_oe_o[5:4] == 2'h3
      && pf_pad_o[5] == $past(pm_data_out_i[0])
      && pf_pad_o[4] == $past(pm_data_out_i[1]))
    else $error("parallel master data missing on second port");
  a_cmp_out: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cmp_on |=> pf_pad_oe_o[1:0] == 2'h3 && pf_pad_o[0] == $past(cmp_out_i[1])
      && pf_pad_o[1] == $past(cmp_out_i[0]))
    else $error("comparator outputs not on pins 1 and 2");
  a_apb_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    psel_i && !penable_i |=> pready_o ##1 !pready_o || (psel_i && !penable_i))
    else $error("ready not a single cycle");

  c_ext_bus: cover property (@(posedge clk_i) ext_here && ext_bus_drive_i);
  c_pwm_shut: cover property (@(posedge clk_i) pwm_shutdown_i && |pwm_en);
  c_pf_digital: cover property (@(posedge clk_i) &pf_digital);
  c_apb_err: cover property (@(posedge clk_i) pslverr_o);
  c_capture: cover property (@(posedge clk_i) pwm2_capture_o);
endmodule

/* File: gpmx_pads.sv */
// Board model for the package pins of port E (5..7) and the second port.
module gpmx_pads (
  // Clock
  input wire logic clk_i,
  // Design side, bits 2:0 port E, bits 9:3 second port
  input wire logic [9:0] pad_o_i,
  input wire logic [9:0] pad_oe_i,
  // Board side
  input wire logic [9:0] brd_en_i,
  input wire logic [9:0] brd_i,
  // Resolved pin levels
  output logic [9:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  logic [9:0] last_q = 10'h000;
  // A floating pin flips every cycle, so a stale level never passes a read.
  always_ff @(posedge clk_i) begin
    last_q <= lvl_o;
  end
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      lvl_o[i] = pad_oe_i[i] ? pad_o_i[i] :
                 (brd_en_i[i] ? brd_i[i] : ~last_q[i]);
    end
  end
endmodule

/* File: gpmx_port_tb.sv */
// Self-checking bench for the port E and second port pin multiplexer.
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module gpmx_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_i = 0;
  logic rst_i = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, cap;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, x, y, r;
  logic p1f = 1, p2f = 0, pmf = 1, micro = 1;
  logic ext_en = 0, ext_drv = 0, pm_en = 0, shut = 0;
  logic p1b_en = 0, p1b = 0, p1c_en = 0, p1c = 0;
  logic p2a_en = 0, p2a = 0, p2c_en = 0, p2c = 0;
  logic [2:0] ext_out = 0, pm_addr = 0, tcfg = 0, ext_in, pe_o, pe_oe, pu, ex;
  logic [6:0] pf_o, pf_oe, cmp_sel;
  logic [5:0] ana;
  logic [1:0] cmp = 2'h0, pmd_out = 2'h0, pmd_in;
  logic pmd_drv = 1'b0;
  logic [9:0] brd = 10'h3f8, lvl;
  logic [7:0] dir, lat;
  int seed = 75;
  int n_errors = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  gpmx_port #(.LARGE_PKG(1'b1)) gpmx_port_inst (
    .clk_i(clk_i), .rst_i(rst_i), .pwm1_pin_select_fuse_i(p1f),
    .pwm2_pin_select_fuse_i(p2f), .parallel_master_pin_select_fuse_i(pmf),
    .micro_mode_i(micro), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ext_bus_en_i(ext_en),
    .ext_bus_drive_i(ext_drv), .ext_bus_out_i(ext_out), .ext_bus_in_o(ext_in),
    .pm_en_i(pm_en), .parallel_master_addr_i(pm_addr),
    .pm_data_drive_i(pmd_drv), .pm_data_out_i(pmd_out), .pm_data_in_o(pmd_in),
    .pwm1_b_en_i(p1b_en), .pwm1_b_i(p1b), .pwm1_c_en_i(p1c_en),
    .pwm1_c_i(p1c), .pwm2_a_en_i(p2a_en), .pwm2_a_i(p2a),
    .pwm2_cmp_en_i(p2c_en), .pwm2_cmp_i(p2c), .pwm_shutdown_i(shut),
    .pwm_tristate_cfg_i(tcfg), .pwm2_capture_o(cap), .cmp_out_i(cmp),
    .cmp_in_sel_o(cmp_sel), .analog_en_o(ana), .pe_pad_i(lvl[2:0]),
    .pe_pad_o(pe_o), .pe_pad_oe_o(pe_oe), .pf_pad_i(lvl[9:3]),
    .pf_pad_o(pf_o), .pf_pad_oe_o(pf_oe), .pullup_o(pu));
  gpmx_pads gpmx_pads_inst (.clk_i(clk_i), .pad_o_i({pf_o, pe_o}),
    .pad_oe_i({pf_oe, pe_oe}), .brd_en_i(10'h3ff), .brd_i(brd), .lvl_o(lvl));
  // ----------------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] rd_v, output logic er);
    int k;
    k = 0;
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_i);
    penable <= 1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) n_errors++;
    rd_v = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] xv);
    apb(0, a, 8'h0, r, e);
    `CHK(r, {24'h0, xv})
  endtask
  // Pin outputs are registered behind synced inputs, so let them land.
  task automatic settle();
    repeat (5) @(posedge clk_i);
    #1;
  endtask
  // Returns {dont_care, oe, out} for port E pin 5 + i.
  function automatic logic [2:0] exp_pe(input int i);
    logic pw;
    logic v;
    logic t;
    pw = (i == 0) ? p1c_en & p1f : (i == 1) ? p1b_en & p1f
       : (p2a_en | p2c_en) & ~p2f & micro;
    v = (i == 0) ? p1c : (i == 1) ? p1b : (p2a_en ? p2a : p2c);
    t = shut & tcfg[i] & ((i != 2) | p2a_en);
    if (ext_en) return {1'b0, ext_drv, ext_out[i]};
    if (pw && !dir[5 + i]) return {1'b0, ~t, v};
    if (pm_en && pmf) return {1'b0, 1'b1, pm_addr[2 - i]};
    return {1'b0, ~dir[5 + i], lat[5 + i]};
  endfunction
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    #1;
    `CHK(ana, 6'h3f)
    `CHK({pf_oe, pe_oe}, 10'h0)
    rd(gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_DIR, gpmx_pkg::RST_DIR);
    rd(gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_LAT, gpmx_pkg::RST_LAT);
    rd(gpmx_pkg::ADDR_PORT_G_PINS_AND_PULLUPS, gpmx_pkg::RST_PORT_G_PINS_AND_PULLUPS);
    rd(gpmx_pkg::ADDR_SECOND_PORT_PINS_DIR, 8'hfe);
    rd(gpmx_pkg::ADDR_ANA_LOW, gpmx_pkg::RST_ANA);
    rd(gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS, {lvl[9], 7'h0});
    apb(1, 12'h0f0, 8'h5a, r, e);
    `CHK({e, r}, 33'h100000000)
    apb(1, gpmx_pkg::ADDR_PORT_G_PINS_AND_PULLUPS, 8'hff, r, e);
    rd(gpmx_pkg::ADDR_PORT_G_PINS_AND_PULLUPS, 8'hff);
    settle();
    `CHK(pu, 3'h7)
    dir = 8'($random(seed));
    lat = 8'($random(seed));
    apb(1, gpmx_pkg::ADDR_SECOND_PORT_PINS_DIR, dir, r, e);
    apb(1, gpmx_pkg::ADDR_SECOND_PORT_PINS_LAT, lat, r, e);
    settle();
    `CHK(pf_oe, ~dir[7:1])
    `CHK(pf_o & ~dir[7:1], lat[7:1] & ~dir[7:1])
    rd(gpmx_pkg::ADDR_SECOND_PORT_PINS_LAT, lat & 8'hfe);
    rd(gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS, {lvl[9], 7'h0});
    cmp <= 2'h2;
    apb(1, gpmx_pkg::ADDR_CMP_CTRL, 8'h01, r, e);
    settle();
    `CHK(cmp_sel, 7'h7c)
    `CHK(pf_oe[1:0], 2'h3)
    `CHK(pf_o[1:0], {cmp[0], cmp[1]})
    apb(1, gpmx_pkg::ADDR_CMP_CTRL, 8'h00, r, e);
    apb(1, gpmx_pkg::ADDR_ANA_LOW, 8'h40, r, e);
    settle();
    `CHK(ana, 6'h3e)
    apb(1, gpmx_pkg::ADDR_ANA_LOW, 8'hc0, r, e);
    apb(1, gpmx_pkg::ADDR_ANA_HIGH, 8'h0f, r, e);
    settle();
    `CHK(ana, 6'h00)
    rd(gpmx_pkg::ADDR_SECOND_PORT_PINS_PINS, {lvl[9:3], 1'b0});
    repeat (24) begin
      @(posedge clk_i);
      x = $random(seed);
      {p1f, p2f, pmf, micro, ext_drv, pm_en, shut} <= x[6:0];
      ext_en <= (x[9:7] == 3'h0);
      ext_out <= x[12:10];
      pm_addr <= x[15:13];
      {p1b_en, p1b, p1c_en, p1c, p2a_en, p2a, p2c_en, p2c} <= x[23:16];
      tcfg <= x[26:24];
      brd[2:0] <= x[29:27];
      y = $random(seed);
      {pmd_out, pmd_drv} <= y[2:0];
      dir = 8'($random(seed));
      lat = 8'($random(seed));
      apb(1, gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_DIR, dir, r, e);
      apb(1, gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_LAT, lat, r, e);
      settle();
      for (int i = 0; i < 3; i++) begin
        ex = exp_pe(i);
        if (!ex[2]) `CHK(pe_oe[i], ex[1])
        if (!ex[2] && ex[1]) `CHK(pe_o[i], ex[0])
      end
      `CHK(ext_in, ext_en ? lvl[2:0] : 3'h0)
      `CHK(cap, ~p2f & micro & dir[7] & lvl[2])
      if (!pmf && pm_en) begin
        `CHK(pf_oe[5:4], {2{pmd_drv}})
        if (pmd_drv) `CHK(pf_o[5:4], {pmd_out[0], pmd_out[1]})
      end
      `CHK(pmd_in, (!pmf && pm_en) ? {lvl[7], lvl[8]} : 2'h0)
      rd(gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_PINS, {lvl[2:0], 5'h0});
      rd(gpmx_pkg::ADDR_PORT_E_PIN_LEVELS_LAT, lat);
    end
    finish_test();
  end
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule
